// >>> design/otf_pkg.sv
// Constants, field layouts, state codes and timing for the overtemperature fault response block.
// Assumes a PMBus front end that decodes transactions into command strobes and a telemetry
// path that delivers die temperature as signed degrees Celsius with four fraction bits.
//
// Summary of operation
// - Fault sets temp summary, fault flag, alert.
// - Warning crossing sets summary, warning flag, alert.
// - Fault releases below warning limit, then restart.
// - Warning above fault limit: use 20C hysteresis.
// - Response byte: action, retry, delay fields.
// - Action 00b ignores fault, keeps running.
// - Action 01b shuts down after delay.
// - Action 10b shuts down immediately, then retries.
// - Action 11b stays off until cooled.
// - Retry zero latches off, no restart.
// - Retry 1-6: hiccup wait, bounded attempts.
// - Attempts while still hot are counted.
// - Retry seven retries without limit.
// - Delay code zero: 10 ms, one rise.
// - Codes 1-7: code ms, 2-4 rises.
// - Unsupported write rejected, flags invalid data.
// - Clear-faults between limits may hold fault.
// - Warning limit high resolution, store rounds.
// - Warning limit 255C disables warning.
// - Warning word: exponent 15:11, mantissa 10:0.
// - Fault when temperature exceeds fault limit.
// - Fault limit 255C disables fault detection.

package otf_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_FAULT_LIMIT = 8'h4f;
    localparam logic [7:0] CMD_RESPONSE = 8'h50;
    localparam logic [7:0] CMD_WARN_LIMIT = 8'h51;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ACTION_HI = 7;
    localparam int ACTION_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MAN_HI = 10;
    localparam int MAN_LO = 0;
    localparam int STATUS_BYTE_TEMP_BIT = 2;
    localparam int STATUS_BYTE_CML_BIT = 1;
    localparam int TEMP_FAULT_BIT = 7;
    localparam int TEMP_WARN_BIT = 6;
    localparam int CML_INVALID_DATA_BIT = 6;

    // ------------------------------------------------------------------
    // Encodings and temperature constants (Q.4 degrees, NVM values in whole degrees)
    // ------------------------------------------------------------------
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_DELAYED = 2'h1;
    localparam logic [1:0] ACT_IMMEDIATE = 2'h2;
    localparam logic [1:0] ACT_UNTIL_COOL = 2'h3;
    localparam logic [2:0] RETRY_LATCH = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam int FRAC_BITS = 4;
    localparam logic signed [15:0] DEG_ZERO = 16'sh0000;
    localparam logic signed [15:0] DEG_DISABLE = 16'sh0ff0;
    localparam logic signed [15:0] DEG_HYSTERESIS = 16'sh0140;
    localparam logic signed [15:0] DEG_HALF = 16'sh0008;
    localparam logic [7:0] NVM_DEG_MAX = 8'ha0;
    localparam logic [7:0] NVM_DEG_DISABLE = 8'hff;
    localparam logic [7:0] DELAY_CODE0_MS = 8'h0a;

    // ------------------------------------------------------------------
    // Values after reset, replaced by the first restore
    // ------------------------------------------------------------------
    localparam logic [7:0] RESPONSE_RESET = 8'h80;
    localparam logic [15:0] WARN_LIMIT_RESET = 16'h0064;
    localparam logic [15:0] FAULT_LIMIT_RESET = 16'h007d;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_CYCLES = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_DELAY = 3'b001,
        ST_COOL = 3'b011,
        ST_HICCUP = 3'b010,
        ST_ATTEMPT = 3'b110,
        ST_LATCHED = 3'b111
    } otf_state_t;

endpackage : otf_pkg

// >>> design/otf_linear_to_fix.sv
// Converts a linear-format word (5-bit exponent, 11-bit mantissa) to Q.4 degrees.
// Purely combinational; out_of_range flags values that do not fit 16 signed bits.
`timescale 1ns/1ps

module otf_linear_to_fix (
    // Linear word
    input wire logic [15:0] linear_word,
    // Fixed-point result
    output logic signed [15:0] fixed_value,
    output logic out_of_range
);

    logic signed [4:0] exponent;
    logic signed [10:0] mantissa;
    logic signed [6:0] shift;
    logic signed [31:0] wide;

    always_comb begin
        exponent = linear_word[otf_pkg::EXP_HI:otf_pkg::EXP_LO];
        mantissa = linear_word[otf_pkg::MAN_HI:otf_pkg::MAN_LO];
        shift = 7'(exponent) + 7'(otf_pkg::FRAC_BITS);
        if (shift >= 0) begin
            wide = 32'(mantissa) <<< shift[4:0];
        end else begin
            wide = 32'(mantissa) >>> 5'(-shift);
        end
        // Left shifts above 20 can push bits off the top, so the shift itself is bounded too.
        out_of_range = (shift > 7'sd20) || (wide > 32'sd32767) || (wide < -32'sd32768);
        fixed_value = wide[15:0];
    end

endmodule : otf_linear_to_fix

// >>> design/otf_fault_response.sv
// Overtemperature supervision and fault response: limit registers, status flags, alert,
// shutdown delay, hiccup restarts and latch-off.
// Assumes commands arrive already decoded as one-cycle strobes and temperature samples as
// one-cycle strobes carrying signed Q.4 degrees; all inputs are synchronous to clk.
`timescale 1ns/1ps

module otf_fault_response #(
    parameter int MS_TICK_CYCLES = otf_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Decoded command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic clear_faults,
    output logic rd_valid,
    output logic [15:0] rd_data,
    // Nonvolatile restore and store
    input wire logic nvm_restore,
    input wire logic [7:0] nvm_response,
    input wire logic [7:0] nvm_warn_deg,
    input wire logic [7:0] nvm_fault_deg,
    input wire logic nvm_store,
    output logic nvm_store_valid,
    output logic [7:0] nvm_store_response,
    output logic [7:0] nvm_store_warn_deg,
    output logic [7:0] nvm_store_fault_deg,
    // Telemetry
    input wire logic temp_valid,
    input wire logic signed [15:0] temp_value,
    // Power stage control
    input wire logic output_on_cmd,
    input wire logic [7:0] ton_rise_ms,
    output logic power_enable,
    // Status
    output logic [7:0] status_byte,
    output logic [7:0] status_temperature,
    output logic [7:0] status_cml,
    output logic alert_n
);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] response_reg;
    logic [15:0] warn_limit_reg;
    logic [15:0] fault_limit_reg;
    logic signed [15:0] warn_q;
    logic signed [15:0] fault_q;
    logic signed [15:0] wdata_q;
    logic warn_ovf;
    logic fault_ovf;
    logic wdata_ovf;
    logic wr_strobe;
    logic wr_limit;
    logic wr_reject;

    otf_linear_to_fix u_warn_conv (.linear_word(warn_limit_reg), .fixed_value(warn_q), .out_of_range(warn_ovf));
    otf_linear_to_fix u_fault_conv (.linear_word(fault_limit_reg), .fixed_value(fault_q), .out_of_range(fault_ovf));
    otf_linear_to_fix u_wdata_conv (.linear_word(cmd_wdata), .fixed_value(wdata_q), .out_of_range(wdata_ovf));

    assign wr_strobe = cmd_valid && cmd_write;
    assign wr_limit = wr_strobe && (cmd_code == otf_pkg::CMD_WARN_LIMIT || cmd_code == otf_pkg::CMD_FAULT_LIMIT);
    // Every response byte has a defined meaning, so only limits outside 0 to 255 degrees are refused.
    assign wr_reject = wr_limit && (wdata_ovf || wdata_q < otf_pkg::DEG_ZERO
        || wdata_q > otf_pkg::DEG_DISABLE);

    always_ff @(posedge clk) begin
        if (reset) begin
            response_reg <= otf_pkg::RESPONSE_RESET;
            warn_limit_reg <= otf_pkg::WARN_LIMIT_RESET;
            fault_limit_reg <= otf_pkg::FAULT_LIMIT_RESET;
        end else if (nvm_restore) begin
            response_reg <= nvm_response;
            warn_limit_reg <= {5'h00, 3'h0, nvm_warn_deg};
            fault_limit_reg <= {5'h00, 3'h0, nvm_fault_deg};
        end else if (wr_strobe && !wr_reject) begin
            if (cmd_code == otf_pkg::CMD_RESPONSE) response_reg <= cmd_wdata[7:0];
            if (cmd_code == otf_pkg::CMD_WARN_LIMIT) warn_limit_reg <= cmd_wdata;
            if (cmd_code == otf_pkg::CMD_FAULT_LIMIT) fault_limit_reg <= cmd_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_valid <= cmd_valid && !cmd_write;
            if (cmd_valid && !cmd_write) begin
                unique case (cmd_code)
                    otf_pkg::CMD_RESPONSE: rd_data <= {8'h00, response_reg};
                    otf_pkg::CMD_WARN_LIMIT: rd_data <= warn_limit_reg;
                    otf_pkg::CMD_FAULT_LIMIT: rd_data <= fault_limit_reg;
                    default: rd_data <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Store: round to whole degrees, clamp to the nonvolatile range
    // ------------------------------------------------------------------
    function automatic logic [7:0] round_to_nvm(input logic signed [15:0] value, input logic ovf);
        logic signed [15:0] rounded;
        rounded = (value + otf_pkg::DEG_HALF) >>> otf_pkg::FRAC_BITS;
        if (!ovf && value == otf_pkg::DEG_DISABLE) begin
            round_to_nvm = otf_pkg::NVM_DEG_DISABLE;
        end else if (ovf || rounded < 16'sd0) begin
            round_to_nvm = 8'h00;
        end else if (rounded > 16'(otf_pkg::NVM_DEG_MAX)) begin
            round_to_nvm = otf_pkg::NVM_DEG_MAX;
        end else begin
            round_to_nvm = rounded[7:0];
        end
    endfunction : round_to_nvm

    always_ff @(posedge clk) begin
        if (reset) begin
            nvm_store_valid <= 1'b0;
            nvm_store_response <= 8'h00;
            nvm_store_warn_deg <= 8'h00;
            nvm_store_fault_deg <= 8'h00;
        end else begin
            nvm_store_valid <= nvm_store;
            if (nvm_store) begin
                nvm_store_response <= response_reg;
                nvm_store_warn_deg <= round_to_nvm(warn_q, warn_ovf);
                nvm_store_fault_deg <= round_to_nvm(fault_q, fault_ovf);
            end
        end
    end

    // ------------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------------
    logic fault_enabled;
    logic warn_enabled;
    logic signed [15:0] release_q;
    logic fault_seen;
    logic warn_seen;
    logic released;
    logic fault_active_reg;
    logic warn_active_reg;

    assign fault_enabled = !(fault_q == otf_pkg::DEG_DISABLE);
    assign warn_enabled = !(warn_q == otf_pkg::DEG_DISABLE);
    // A warning limit above the fault limit, disabled included, would leave no hysteresis band.
    assign release_q = (warn_q > fault_q) ? fault_q - otf_pkg::DEG_HYSTERESIS : warn_q;
    // Limits are read live, so a write counts from the next sample.
    assign fault_seen = temp_valid && fault_enabled && (temp_value > fault_q);
    assign warn_seen = temp_valid && warn_enabled && (temp_value > warn_q);
    assign released = temp_valid && (temp_value < release_q);

    always_ff @(posedge clk) begin
        if (reset) begin
            fault_active_reg <= 1'b0;
            warn_active_reg <= 1'b0;
        end else begin
            // Clear-faults leaves these alone; a fault set in the band holds until cooled or until fault
            // detection is disabled, which is why the host should not clear in that band.
            if (fault_seen) begin
                fault_active_reg <= 1'b1;
            end else if (released || !fault_enabled) begin
                fault_active_reg <= 1'b0;
            end
            if (temp_valid) begin
                warn_active_reg <= warn_seen;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags and alert (a new event beats a same-cycle clear)
    // ------------------------------------------------------------------
    logic fault_flag_reg;
    logic warning_flag_reg;
    logic invalid_data_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            fault_flag_reg <= 1'b0;
            warning_flag_reg <= 1'b0;
            invalid_data_reg <= 1'b0;
            alert_n <= 1'b1;
        end else begin
            if (fault_seen) begin
                fault_flag_reg <= 1'b1;
            end else if (clear_faults) begin
                fault_flag_reg <= 1'b0;
            end
            if (warn_seen && !warn_active_reg) begin
                warning_flag_reg <= 1'b1;
            end else if (clear_faults) begin
                warning_flag_reg <= 1'b0;
            end
            if (wr_reject) begin
                invalid_data_reg <= 1'b1;
            end else if (clear_faults) begin
                invalid_data_reg <= 1'b0;
            end
            alert_n <= !(fault_seen || (warn_seen && !warn_active_reg) || wr_reject
                || ((fault_flag_reg || warning_flag_reg || invalid_data_reg) && !clear_faults));
        end
    end

    always_comb begin
        status_temperature = 8'h00;
        status_temperature[otf_pkg::TEMP_FAULT_BIT] = fault_flag_reg;
        status_temperature[otf_pkg::TEMP_WARN_BIT] = warning_flag_reg;
        status_cml = 8'h00;
        status_cml[otf_pkg::CML_INVALID_DATA_BIT] = invalid_data_reg;
        status_byte = 8'h00;
        status_byte[otf_pkg::STATUS_BYTE_TEMP_BIT] = fault_flag_reg || warning_flag_reg;
        status_byte[otf_pkg::STATUS_BYTE_CML_BIT] = invalid_data_reg;
    end

    // ------------------------------------------------------------------
    // Millisecond timer
    // ------------------------------------------------------------------
    logic [1:0] action;
    logic [2:0] retry_count;
    logic [2:0] delay_code;
    logic [7:0] delay_ms;
    logic [2:0] hiccup_mult;
    logic [9:0] hiccup_ms;
    logic [16:0] prescale_reg;
    logic [9:0] timer_reg;
    logic timer_load;
    logic [9:0] timer_load_val;
    logic ms_tick;
    logic timer_done;

    assign action = response_reg[otf_pkg::ACTION_HI:otf_pkg::ACTION_LO];
    assign retry_count = response_reg[otf_pkg::RETRY_HI:otf_pkg::RETRY_LO];
    assign delay_code = response_reg[otf_pkg::DELAY_HI:otf_pkg::DELAY_LO];
    assign delay_ms = (delay_code == 3'h0) ? otf_pkg::DELAY_CODE0_MS : {5'h00, delay_code};
    // Codes 1-7 spread over two to four rise times in three bands.
    assign hiccup_mult = (delay_code == 3'h0) ? 3'h1 : (delay_code < 3'h3) ? 3'h2
        : (delay_code < 3'h6) ? 3'h3 : 3'h4;
    assign hiccup_ms = (ton_rise_ms == 8'h00) ? 10'h001 : 10'(ton_rise_ms * hiccup_mult);
    assign ms_tick = (prescale_reg == 17'(MS_TICK_CYCLES - 1));
    assign timer_done = (timer_reg == 10'h000);

    always_ff @(posedge clk) begin
        if (reset) begin
            prescale_reg <= 17'h00000;
            timer_reg <= 10'h000;
        end else if (timer_load) begin
            // Restarting the prescaler keeps every wait a whole number of milliseconds at least.
            prescale_reg <= 17'h00000;
            timer_reg <= timer_load_val;
        end else begin
            prescale_reg <= ms_tick ? 17'h00000 : prescale_reg + 17'h00001;
            if (ms_tick && !timer_done) begin
                timer_reg <= timer_reg - 10'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Response sequencer
    // ------------------------------------------------------------------
    otf_pkg::otf_state_t state_reg;
    otf_pkg::otf_state_t state_next;
    logic [2:0] attempts_reg;
    logic [2:0] attempts_next;

    always_comb begin
        state_next = state_reg;
        attempts_next = attempts_reg;
        timer_load = 1'b0;
        timer_load_val = hiccup_ms;
        if (!output_on_cmd) begin
            // Commanded off clears any latch or pending retry.
            state_next = otf_pkg::ST_RUN;
            attempts_next = 3'h0;
        end else begin
            unique case (state_reg)
                otf_pkg::ST_RUN: begin
                    if (fault_active_reg) begin
                        unique case (action)
                            otf_pkg::ACT_IGNORE: state_next = otf_pkg::ST_RUN;
                            otf_pkg::ACT_DELAYED: begin
                                state_next = otf_pkg::ST_DELAY;
                                timer_load = 1'b1;
                                timer_load_val = {2'h0, delay_ms};
                            end
                            otf_pkg::ACT_IMMEDIATE: begin
                                timer_load = 1'b1;
                                attempts_next = 3'h0;
                                state_next = (retry_count == otf_pkg::RETRY_LATCH) ? otf_pkg::ST_LATCHED
                                    : otf_pkg::ST_HICCUP;
                            end
                            otf_pkg::ACT_UNTIL_COOL: state_next = otf_pkg::ST_COOL;
                        endcase
                    end
                end
                otf_pkg::ST_DELAY: begin
                    if (!fault_active_reg) begin
                        state_next = otf_pkg::ST_RUN;
                    end else if (timer_done) begin
                        timer_load = 1'b1;
                        attempts_next = 3'h0;
                        state_next = (retry_count == otf_pkg::RETRY_LATCH) ? otf_pkg::ST_LATCHED
                            : otf_pkg::ST_HICCUP;
                    end
                end
                otf_pkg::ST_COOL: begin
                    if (!fault_active_reg) begin
                        timer_load = 1'b1;
                        attempts_next = 3'h0;
                        state_next = (retry_count == otf_pkg::RETRY_LATCH) ? otf_pkg::ST_LATCHED
                            : otf_pkg::ST_HICCUP;
                    end
                end
                otf_pkg::ST_HICCUP: begin
                    if (timer_done) begin
                        state_next = otf_pkg::ST_ATTEMPT;
                    end
                end
                otf_pkg::ST_ATTEMPT: begin
                    if (!fault_active_reg) begin
                        state_next = otf_pkg::ST_RUN;
                        attempts_next = 3'h0;
                    end else if (retry_count == otf_pkg::RETRY_FOREVER) begin
                        state_next = otf_pkg::ST_HICCUP;
                        timer_load = 1'b1;
                    end else begin
                        // A hot attempt never reaches the output but still uses up a retry.
                        attempts_next = attempts_reg + 3'h1;
                        if (attempts_reg + 3'h1 >= retry_count) begin
                            state_next = otf_pkg::ST_LATCHED;
                        end else begin
                            state_next = otf_pkg::ST_HICCUP;
                            timer_load = 1'b1;
                        end
                    end
                end
                otf_pkg::ST_LATCHED: state_next = otf_pkg::ST_LATCHED;
                default: state_next = otf_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= otf_pkg::ST_RUN;
            attempts_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            attempts_reg <= attempts_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            power_enable <= 1'b0;
        end else begin
            power_enable <= output_on_cmd && (state_next == otf_pkg::ST_RUN || state_next == otf_pkg::ST_DELAY);
        end
    end

endmodule : otf_fault_response

// >>> verif/otf_host_model.sv
// Host model: issues decoded reads and writes on the command port.
// Assumes the block's clock; drives on the falling edge.
`timescale 1ns/1ps

module otf_host_model (
    // Clock and answer
    input wire logic clk,
    input wire logic [15:0] rd_data,
    // Command drive
    output logic cmd_valid = 1'b0,
    output logic cmd_write = 1'b0,
    output logic [7:0] cmd_code = 8'h00,
    output logic [15:0] cmd_wdata = 16'h0000
);
    // Idle lines show the inverse of the last word so a stale value is never taken.
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_wdata = d;
        @(negedge clk);
        q = rd_data;
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask : xfer
endmodule : otf_host_model

// >>> verif/otf_fault_response_checker.sv
// Checker for the overtemperature fault response block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps

module otf_fault_response_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched ports
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic clear_faults,
    input wire logic rd_valid,
    input wire logic nvm_store,
    input wire logic nvm_store_valid,
    input wire logic [7:0] nvm_store_warn_deg,
    input wire logic output_on_cmd,
    input wire logic power_enable,
    input wire logic [7:0] status_byte,
    input wire logic [7:0] status_temperature,
    input wire logic [7:0] status_cml,
    input wire logic alert_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_read;
        cmd_valid && !cmd_write;
    endsequence
    a_read_answer: assert property (s_read |=> rd_valid) else $error("read unanswered");
    a_no_stray: assert property (!cmd_valid |=> !rd_valid) else $error("stray read pulse");
    a_flag_alert: assert property ((status_temperature[7] || status_temperature[6]
        || status_cml[6]) |-> !alert_n) else $error("flag without alert");
    a_temp_summary: assert property (status_byte[2] == (status_temperature[7] || status_temperature[6]))
        else $error("temp summary wrong");
    a_fault_sticky: assert property (status_temperature[7] && !clear_faults |=> status_temperature[7])
        else $error("fault flag lost");
    a_store_answer: assert property (nvm_store |=> nvm_store_valid) else $error("store unanswered");
    a_store_range: assert property (nvm_store_valid |-> nvm_store_warn_deg <= 8'ha0
        || nvm_store_warn_deg == 8'hff) else $error("stored limit out of range");
    a_off_cmd: assert property (!output_on_cmd |=> !power_enable) else $error("on while off");
endmodule : otf_fault_response_checker

// >>> verif/otf_fault_response_tb.sv
// Bench for the overtemperature fault response block.
// Assumes the host model owns the command port and a 1 ms tick of 10 cycles.
`timescale 1ns/1ps

module otf_fault_response_tb;
    logic clk = 0, reset = 1, clear_faults = 0, temp_valid = 0, output_on_cmd = 1, nvm_store = 0, nvm_restore = 0;
    logic signed [15:0] temp_value = 16'sh0000;
    logic [7:0] ton_rise_ms = 8'h01, nvm_response = 8'h51, nvm_warn_deg = 8'h64, nvm_fault_deg = 8'h7d;
    logic rd_valid, cmd_valid, cmd_write, nvm_store_valid, power_enable, alert_n;
    logic [7:0] cmd_code, nvm_store_response, nvm_store_warn_deg, nvm_store_fault_deg;
    logic [7:0] status_byte, status_temperature, status_cml;
    logic [15:0] cmd_wdata, rd_data, q;
    int n_mismatch = 0, num_checks = 0;
    always #4 clk = ~clk;
    otf_fault_response #(.MS_TICK_CYCLES(10)) u_dut (.*);
    otf_host_model u_host (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic samp(input logic [15:0] t);
        @(negedge clk);
        temp_value = t;
        temp_valid = 1'b1;
        @(negedge clk);
        temp_valid = 1'b0;
        @(negedge clk);
    endtask : samp
    // Faults are cleared when cool or with fault detection disabled, never between the limits under cool-down.
    task automatic clr;
        @(negedge clk);
        clear_faults = 1'b1;
        @(negedge clk);
        clear_faults = 1'b0;
    endtask : clr
    task automatic rd(input logic [7:0] c);
        u_host.xfer(1'b0, c, 16'h0000, q);
    endtask : rd
    task automatic t_regs;
        rd(8'h50);
        chk(q, 16'h0080);
        rd(8'h51);
        chk(q, 16'h0064);
        u_host.xfer(1'b1, 8'h51, 16'h07ff, q);
        rd(8'h51);
        chk({q[7:0], 5'h0, status_cml[6], status_byte[1], alert_n}, 16'h6406);
        u_host.xfer(1'b1, 8'h50, 16'h00d3, q);
        rd(8'h50);
        chk(q, 16'h00d3);
        clr;
        $display("t_regs done");
    endtask : t_regs
    task automatic t_paths;
        u_host.xfer(1'b1, 8'h50, 16'h0000, q);
        samp(16'h0820);
        chk({13'h0, power_enable, status_temperature[7], status_byte[2]}, 16'h0007);
        samp(16'h0320);
        clr;
        u_host.xfer(1'b1, 8'h50, 16'h0080, q);
        samp(16'h0820);
        chk({13'h0, power_enable, status_temperature[7], alert_n}, 16'h0002);
        samp(16'h0320);
        repeat (30) @(negedge clk);
        chk({15'h0, power_enable}, 16'h0000);
        output_on_cmd = 1'b0;
        @(negedge clk);
        output_on_cmd = 1'b1;
        repeat (2) @(negedge clk);
        chk({15'h0, power_enable}, 16'h0001);
        clr;
        $display("t_paths done");
    endtask : t_paths
    task automatic t_cool;
        u_host.xfer(1'b1, 8'h50, 16'h00d9, q);
        samp(16'h0820);
        samp(16'h0640);
        repeat (40) @(negedge clk);
        chk({15'h0, power_enable}, 16'h0000);
        samp(16'h0320);
        repeat (40) @(negedge clk);
        chk({15'h0, power_enable}, 16'h0001);
        clr;
        $display("t_cool done");
    endtask : t_cool
    task automatic t_limits;
        u_host.xfer(1'b1, 8'h50, 16'h0000, q);
        samp(16'h06e0);
        chk({8'h00, status_temperature}, 16'h0040);
        u_host.xfer(1'b1, 8'h4f, 16'h00ff, q);
        clr;
        samp(16'h0c80);
        chk({15'h0, status_temperature[7]}, 16'h0000);
        nvm_store = 1'b1;
        @(negedge clk);
        nvm_store = 1'b0;
        chk({nvm_store_warn_deg, nvm_store_fault_deg}, 16'h64ff);
        $display("t_limits done");
    endtask : t_limits
    task automatic t_retry;
        nvm_restore = 1'b1;
        @(negedge clk);
        nvm_restore = 1'b0;
        nvm_store = 1'b1;
        @(negedge clk);
        nvm_store = 1'b0;
        chk({nvm_store_response, nvm_store_fault_deg}, 16'h517d);
        samp(16'h0820);
        repeat (8) @(negedge clk);
        chk({15'h0, power_enable}, 16'h0001);
        repeat (6) @(negedge clk);
        chk({15'h0, power_enable}, 16'h0000);
        repeat (50) @(negedge clk);
        samp(16'h0320);
        repeat (30) @(negedge clk);
        chk({15'h0, power_enable}, 16'h0000);
        $display("t_retry done");
    endtask : t_retry
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        t_regs;
        t_paths;
        t_cool;
        t_limits;
        t_retry;
        stop_test;
    end
    initial begin
        #20000;
        n_mismatch++;
        stop_test;
    end
endmodule : otf_fault_response_tb
bind otf_fault_response otf_fault_response_checker u_chk (.*);
